// ---- common/ebi_defs.svh ----
`ifndef EBI_DEFS_SVH
`define EBI_DEFS_SVH

// register byte offsets on the apb bus
`define EBI_OFF_ROLE 12'h000
`define EBI_OFF_CODE_WAIT 12'h004
`define EBI_OFF_DATA_WAIT 12'h008
`define EBI_OFF_STATUS 12'h00C

// pin role bits in the role register
`define EBI_ROLE_LOW 0
`define EBI_ROLE_HIGH 1
`define EBI_ROLE_LATCH 2
`define EBI_ROLE_WRITE 3
`define EBI_ROLE_READ 4

// status register fields
`define EBI_ST_BUSY 0
`define EBI_ST_STRAP 1
`define EBI_ST_DUMMY_LO 2
`define EBI_ST_DUMMY_HI 3

// reset values
`define EBI_ROLE_RST 5'h00
`define EBI_ROLE_STRAP 5'h07
`define EBI_CODE_WAIT_RST 4'h0
`define EBI_DATA_WAIT_RST 4'h0

// data space split
`define EBI_INT_TOP 16'h09FF

// strobe lengths in clock cycles before programmed waits
`define EBI_AUTO_RD 5'h02
`define EBI_AUTO_WR 5'h03
`define EBI_FETCH_BASE 5'h01

`endif

// ---- common/ebi_pkg.sv ----
package ebi_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_STROBE
    } ebi_state_t;

    typedef logic [1:0] ebi_dummy_t;

endpackage : ebi_pkg

// ---- logic/ebi_wait_cnt.sv ----
`timescale 1ns/100ps
`default_nettype none

// down counter that stretches a strobe
module ebi_wait_cnt (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [4:0] load_val,
    output logic expired
);

    logic [4:0] count_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 5'h00;
        end else if (load) begin
            count_reg <= load_val;
        end else if (count_reg != 5'h00) begin
            count_reg <= count_reg - 5'h01;
        end
    end

    assign expired = (count_reg == 5'h00);

endmodule : ebi_wait_cnt

`default_nettype wire

// ---- logic/ebi_dummy_dec.sv ----
`timescale 1ns/100ps
`default_nettype none

// number of spurious reads for a two-part write
module ebi_dummy_dec (
    input wire logic two_part,
    input wire logic word,
    input wire logic [7:0] addr_code,
    input wire logic [7:0] op_code,
    output ebi_pkg::ebi_dummy_t dummies
);

    function automatic logic byte_op(input logic [7:0] c);
        byte_op = (c[7:3] == 5'h01) || (c[7:3] == 5'h00) || (c[7:3] == 5'h03) ||
                  (c == 8'hB8) || (c == 8'hB9) || (c == 8'hCA) || (c == 8'hBB) ||
                  (c == 8'hBA) || (c == 8'hAA) || (c == 8'hAB) || (c == 8'hC7) ||
                  (c == 8'hD7);
    endfunction : byte_op

    function automatic logic byte_addr(input logic [7:0] c);
        byte_addr = (c[7:3] == 5'h0D) || (c[7:2] == 6'h2C) || (c == 8'hB5) ||
                    (c == 8'hB7) || (c == 8'hB8) || (c == 8'hB9) || (c == 8'hBA) ||
                    (c == 8'hBB) || (c == 8'h9B);
    endfunction : byte_addr

    function automatic logic word_op(input logic [7:0] c);
        word_op = (c == 8'hAA) || (c == 8'hAB) || (c == 8'hC7) || (c == 8'hD7);
    endfunction : word_op

    function automatic logic word_addr(input logic [7:0] c);
        word_addr = (c[7:2] == 6'h19) || (c[7:2] == 6'h28) || (c == 8'hA5) ||
                    (c == 8'hA7) || (c[7:2] == 6'h2A) || (c == 8'h8B);
    endfunction : word_addr

    always_comb begin
        dummies = 2'h0;
        if (two_part) begin
            if (word && word_op(op_code) && word_addr(addr_code)) begin
                dummies = 2'h2;
            end else if (!word && byte_op(op_code) && byte_addr(addr_code)) begin
                dummies = 2'h1;
            end
        end
    end

endmodule : ebi_dummy_dec

`default_nettype wire

// ---- logic/ebi_top.sv ----
// Functional notes
// - data space is 64KB, reached through a 16-bit data space pointer
// - addresses up to 9FFH are internal, A00H to FFFFH go out on the bus
// - one byte per external bus cycle; words become two byte cycles
// - internal program disable low sets low, high and latch pin roles at reset
// - external program fetches add the code wait count
// - external data byte access takes two or three automatic extra cycles
// - data wait count adds programmed waits to each external data byte
// - two-part write to external area emits spurious reads before writing
// - one spurious read for byte or bit writes, two for word writes
// - single-part accumulator loads and stores emit no spurious read
// - single-part is 1-4 bytes; two-part is 1-3 plus 1-3 bytes
// - listed byte and bit operation parts give one spurious read
// - listed byte operand-address parts qualify for the spurious read
// - listed word operation and operand-address parts give two reads
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "ebi_defs.svh"
`default_nettype none

module ebi_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic internal_rom_disable_n,
    input wire logic cpu_req,
    output logic cpu_ready,
    input wire logic cpu_fetch,
    input wire logic cpu_write,
    input wire logic cpu_word,
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    input wire logic cpu_two_part,
    input wire logic [7:0] cpu_addr_code,
    input wire logic [7:0] cpu_op_code,
    output logic cpu_done,
    output logic [15:0] cpu_rdata,
    output logic int_sel,
    output logic [15:0] int_addr,
    input wire logic [7:0] low_addr_data_port_i,
    output logic [7:0] low_addr_data_port_o,
    output logic low_addr_data_port_oe,
    output logic [7:0] high_addr_port_o,
    output logic high_addr_port_oe,
    output logic latch_strobe_pin_o,
    output logic latch_strobe_pin_oe,
    output logic write_strobe_pin_n_o,
    output logic write_strobe_pin_oe,
    output logic read_strobe_pin_n_o,
    output logic read_strobe_pin_oe,
    output logic fetch_strobe_n_o
);

    // configuration and status
    logic [4:0] role_reg;
    logic [3:0] code_wait_count_reg;
    logic [3:0] data_wait_count_reg;
    logic strap_done_reg;
    logic [31:0] prdata_reg;

    // bus cycle state
    ebi_pkg::ebi_state_t state_reg;
    ebi_pkg::ebi_state_t state_next;
    logic [15:0] data_space_pointer_reg;
    logic [15:0] wdata_reg;
    logic write_reg;
    logic fetch_reg;
    logic word_reg;
    ebi_pkg::ebi_dummy_t dummy_reg;
    logic [2:0] total_reg;
    logic [2:0] idx_reg;
    logic [15:0] rdata_reg;
    logic done_reg;
    logic int_sel_reg;
    logic [15:0] int_addr_reg;

    // decoded request
    logic accept;
    logic is_internal;
    ebi_pkg::ebi_dummy_t dummies;
    logic [2:0] dummy_ext;
    logic [2:0] byte_idx;
    logic in_dummy;
    logic data_write;
    logic [15:0] cyc_addr;
    logic [4:0] strobe_len;
    logic wait_load;
    logic wait_expired;
    logic last_cycle;

    // apb decode
    logic apb_setup;
    logic apb_write;
    logic addr_hit;

    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;
    assign addr_hit = (paddr == `EBI_OFF_ROLE) || (paddr == `EBI_OFF_CODE_WAIT) ||
                      (paddr == `EBI_OFF_DATA_WAIT) || (paddr == `EBI_OFF_STATUS);
    assign pready = psel && penable;
    assign pslverr = psel && penable && !addr_hit;
    assign prdata = prdata_reg;

    // pin roles: software writes, strap applied once after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            role_reg <= `EBI_ROLE_RST;
            strap_done_reg <= 1'b0;
        end else begin
            if (!strap_done_reg) begin
                strap_done_reg <= 1'b1;
                if (!internal_rom_disable_n) begin
                    role_reg <= role_reg | `EBI_ROLE_STRAP;
                end
            end else if (apb_write && pstrb[0] && (paddr == `EBI_OFF_ROLE)) begin
                role_reg <= pwdata[4:0];
            end
        end
    end

    // wait count settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_wait_count_reg <= `EBI_CODE_WAIT_RST;
            data_wait_count_reg <= `EBI_DATA_WAIT_RST;
        end else if (apb_write && pstrb[0]) begin
            if (paddr == `EBI_OFF_CODE_WAIT) begin
                code_wait_count_reg <= pwdata[3:0];
            end
            if (paddr == `EBI_OFF_DATA_WAIT) begin
                data_wait_count_reg <= pwdata[3:0];
            end
        end
    end

    // read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (apb_setup) begin
            prdata_reg <= 32'h00000000;
            if (paddr == `EBI_OFF_ROLE) begin
                prdata_reg[4:0] <= role_reg;
            end
            if (paddr == `EBI_OFF_CODE_WAIT) begin
                prdata_reg[3:0] <= code_wait_count_reg;
            end
            if (paddr == `EBI_OFF_DATA_WAIT) begin
                prdata_reg[3:0] <= data_wait_count_reg;
            end
            if (paddr == `EBI_OFF_STATUS) begin
                prdata_reg[`EBI_ST_BUSY] <= (state_reg != ebi_pkg::ST_IDLE);
                prdata_reg[`EBI_ST_STRAP] <= strap_done_reg && !internal_rom_disable_n;
                prdata_reg[`EBI_ST_DUMMY_HI:`EBI_ST_DUMMY_LO] <= dummy_reg;
            end
        end
    end

    // spurious read count for the request on the cpu port
    ebi_dummy_dec u_dummy_dec (
        .two_part(cpu_two_part && cpu_write && !cpu_fetch),
        .word(cpu_word),
        .addr_code(cpu_addr_code),
        .op_code(cpu_op_code),
        .dummies(dummies)
    );

    assign cpu_ready = (state_reg == ebi_pkg::ST_IDLE);
    assign accept = cpu_req && cpu_ready;
    assign is_internal = !cpu_fetch && (cpu_addr <= `EBI_INT_TOP);

    // current byte cycle: spurious reads first, then the real bytes
    assign dummy_ext = {1'b0, dummy_reg};
    assign in_dummy = (idx_reg < dummy_ext);
    assign byte_idx = in_dummy ? idx_reg : (idx_reg - dummy_ext);
    assign data_write = write_reg && !in_dummy;
    assign cyc_addr = data_space_pointer_reg + {15'h0000, byte_idx[0]};
    assign last_cycle = (idx_reg == (total_reg - 3'h1));

    // strobe length for this byte cycle
    always_comb begin
        if (fetch_reg) begin
            strobe_len = `EBI_FETCH_BASE + {1'b0, code_wait_count_reg};
        end else if (data_write) begin
            strobe_len = `EBI_AUTO_WR + {1'b0, data_wait_count_reg};
        end else begin
            strobe_len = `EBI_AUTO_RD + {1'b0, data_wait_count_reg};
        end
    end

    assign wait_load = (state_reg == ebi_pkg::ST_ADDR);

    ebi_wait_cnt u_wait_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .load(wait_load),
        .load_val(strobe_len - 5'h01),
        .expired(wait_expired)
    );

    // cycle sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ebi_pkg::ST_IDLE: begin
                if (accept && !is_internal) begin
                    state_next = ebi_pkg::ST_ADDR;
                end
            end
            ebi_pkg::ST_ADDR: begin
                state_next = ebi_pkg::ST_STROBE;
            end
            ebi_pkg::ST_STROBE: begin
                if (wait_expired) begin
                    state_next = last_cycle ? ebi_pkg::ST_IDLE : ebi_pkg::ST_ADDR;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ebi_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // request capture, held for the whole access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_space_pointer_reg <= 16'h0000;
            wdata_reg <= 16'h0000;
            write_reg <= 1'b0;
            fetch_reg <= 1'b0;
            word_reg <= 1'b0;
            dummy_reg <= 2'h0;
            total_reg <= 3'h1;
        end else if (accept && !is_internal) begin
            data_space_pointer_reg <= cpu_addr;
            wdata_reg <= cpu_wdata;
            write_reg <= cpu_write && !cpu_fetch;
            fetch_reg <= cpu_fetch;
            word_reg <= cpu_word && !cpu_fetch;
            dummy_reg <= dummies;
            total_reg <= {1'b0, dummies} + ((cpu_word && !cpu_fetch) ? 3'h2 : 3'h1);
        end
    end

    // byte cycle index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_reg <= 3'h0;
        end else if (accept) begin
            idx_reg <= 3'h0;
        end else if ((state_reg == ebi_pkg::ST_STROBE) && wait_expired && !last_cycle) begin
            idx_reg <= idx_reg + 3'h1;
        end
    end

    // read data assembled low byte first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 16'h0000;
        end else if (accept) begin
            rdata_reg <= 16'h0000;
        end else if ((state_reg == ebi_pkg::ST_STROBE) && wait_expired && !in_dummy && !write_reg) begin
            if (byte_idx[0]) begin
                rdata_reg[15:8] <= low_addr_data_port_i;
            end else begin
                rdata_reg[7:0] <= low_addr_data_port_i;
            end
        end
    end

    // completion and internal memory select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_reg <= 1'b0;
            int_sel_reg <= 1'b0;
            int_addr_reg <= 16'h0000;
        end else begin
            done_reg <= (accept && is_internal) ||
                        ((state_reg == ebi_pkg::ST_STROBE) && wait_expired && last_cycle);
            int_sel_reg <= accept && is_internal;
            if (accept && is_internal) begin
                int_addr_reg <= cpu_addr;
            end
        end
    end

    assign cpu_done = done_reg;
    assign cpu_rdata = rdata_reg;
    assign int_sel = int_sel_reg;
    assign int_addr = int_addr_reg;

    // pin drive from held state
    always_comb begin
        low_addr_data_port_o = 8'h00;
        low_addr_data_port_oe = 1'b0;
        high_addr_port_o = 8'h00;
        high_addr_port_oe = 1'b0;
        latch_strobe_pin_o = 1'b0;
        write_strobe_pin_n_o = 1'b1;
        read_strobe_pin_n_o = 1'b1;
        fetch_strobe_n_o = 1'b1;
        if (state_reg == ebi_pkg::ST_ADDR) begin
            latch_strobe_pin_o = 1'b1;
            low_addr_data_port_o = cyc_addr[7:0];
            low_addr_data_port_oe = role_reg[`EBI_ROLE_LOW];
        end
        if (state_reg != ebi_pkg::ST_IDLE) begin
            high_addr_port_o = cyc_addr[15:8];
            high_addr_port_oe = role_reg[`EBI_ROLE_HIGH];
        end
        if (state_reg == ebi_pkg::ST_STROBE) begin
            if (fetch_reg) begin
                fetch_strobe_n_o = 1'b0;
            end else if (data_write) begin
                write_strobe_pin_n_o = 1'b0;
                low_addr_data_port_o = byte_idx[0] ? wdata_reg[15:8] : wdata_reg[7:0];
                low_addr_data_port_oe = role_reg[`EBI_ROLE_LOW];
            end else begin
                read_strobe_pin_n_o = 1'b0;
            end
        end
    end

    assign latch_strobe_pin_oe = role_reg[`EBI_ROLE_LATCH];
    assign write_strobe_pin_oe = role_reg[`EBI_ROLE_WRITE];
    assign read_strobe_pin_oe = role_reg[`EBI_ROLE_READ];

endmodule : ebi_top

`default_nettype wire

// ---- verif/ebi_checker.sv ----
`timescale 1ns/100ps
`include "ebi_defs.svh"
`default_nettype none

module ebi_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic cpu_req,
    input wire logic cpu_ready,
    input wire logic cpu_fetch,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_done,
    input wire logic int_sel,
    input wire logic [7:0] low_addr_data_port_o,
    input wire logic low_addr_data_port_oe,
    input wire logic [7:0] high_addr_port_o,
    input wire logic latch_strobe_pin_o,
    input wire logic write_strobe_pin_n_o,
    input wire logic read_strobe_pin_n_o,
    input wire logic fetch_strobe_n_o
);
    logic [3:0] dw_reg;
    logic [3:0] cw_reg;
    logic [4:0] rd_len_reg;
    logic [4:0] wr_len_reg;
    logic [4:0] fe_len_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // shadow copies of the wait counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dw_reg <= 4'h0;
            cw_reg <= 4'h0;
        end else if (psel && penable && pwrite && pstrb[0]) begin
            if (paddr == `EBI_OFF_DATA_WAIT) dw_reg <= pwdata[3:0];
            if (paddr == `EBI_OFF_CODE_WAIT) cw_reg <= pwdata[3:0];
        end
    end

    // length of the strobe now running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_len_reg <= 5'h00;
            wr_len_reg <= 5'h00;
            fe_len_reg <= 5'h00;
        end else begin
            rd_len_reg <= read_strobe_pin_n_o ? 5'h00 : rd_len_reg + 5'h01;
            wr_len_reg <= write_strobe_pin_n_o ? 5'h00 : wr_len_reg + 5'h01;
            fe_len_reg <= fetch_strobe_n_o ? 5'h00 : fe_len_reg + 5'h01;
        end
    end

    sequence s_int_acc;
        cpu_req && cpu_ready && !cpu_fetch && cpu_addr <= `EBI_INT_TOP;
    endsequence
    sequence s_ext_acc;
        cpu_req && cpu_ready && !cpu_fetch && cpu_addr > `EBI_INT_TOP;
    endsequence
    sequence s_addr_phase;
        latch_strobe_pin_o && !int_sel && {high_addr_port_o, low_addr_data_port_o} == $past(cpu_addr);
    endsequence

    AST_INT_DONE: assert property (s_int_acc |=> int_sel && cpu_done && !latch_strobe_pin_o)
        else $error("internal access not answered in one cycle");
    AST_INT_QUIET: assert property (int_sel |-> read_strobe_pin_n_o && write_strobe_pin_n_o)
        else $error("strobe during internal access");
    AST_EXT_ADDR: assert property (s_ext_acc |=> s_addr_phase ##1 !latch_strobe_pin_o)
        else $error("external address phase wrong");
    AST_RD_LEN: assert property ($rose(read_strobe_pin_n_o) |-> rd_len_reg == 5'h02 + {1'b0, dw_reg})
        else $error("read strobe length wrong");
    AST_WR_LEN: assert property ($rose(write_strobe_pin_n_o) |-> wr_len_reg == 5'h03 + {1'b0, dw_reg})
        else $error("write strobe length wrong");
    AST_FE_LEN: assert property ($rose(fetch_strobe_n_o) |-> fe_len_reg == 5'h01 + {1'b0, cw_reg})
        else $error("fetch strobe length wrong");
    AST_RD_RELEASE: assert property (!read_strobe_pin_n_o |-> !low_addr_data_port_oe)
        else $error("port driven during read");
    AST_ADDR_HOLD: assert property ((!read_strobe_pin_n_o && $past(!read_strobe_pin_n_o))
        |-> $stable(high_addr_port_o)) else $error("address moved in read strobe");
    AST_WR_HOLD: assert property ((!write_strobe_pin_n_o && $past(!write_strobe_pin_n_o))
        |-> $stable(high_addr_port_o) && $stable(low_addr_data_port_o)) else $error("write moved in strobe");
endmodule : ebi_checker

bind ebi_top ebi_checker i_chk (.*);

`default_nettype wire

// ---- verif/ebi_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module ebi_mem_model (
    input wire logic pclk,
    input wire logic [7:0] low_addr_data_port_o,
    input wire logic [7:0] high_addr_port_o,
    input wire logic latch_strobe_pin_o,
    input wire logic write_strobe_pin_n_o,
    input wire logic read_strobe_pin_n_o,
    output logic [7:0] low_addr_data_port_i
);
    logic [7:0] mem [0:65535];
    logic [7:0] lo_reg = 8'h00;
    logic [7:0] last_reg = 8'h00;
    logic rd_prev = 1'b1;
    logic wr_prev = 1'b1;
    int rd_count = 0;
    int wr_count = 0;

    // one byte per strobe; released bus shows the inverse of the last byte
    assign low_addr_data_port_i = read_strobe_pin_n_o ? ~last_reg : mem[{high_addr_port_o, lo_reg}];
    always @(posedge pclk) begin
        if (latch_strobe_pin_o) lo_reg <= low_addr_data_port_o;
        if (!read_strobe_pin_n_o) last_reg <= mem[{high_addr_port_o, lo_reg}];
        if (!write_strobe_pin_n_o) mem[{high_addr_port_o, lo_reg}] <= low_addr_data_port_o;
        if (!read_strobe_pin_n_o && rd_prev) rd_count <= rd_count + 1;
        if (!write_strobe_pin_n_o && wr_prev) wr_count <= wr_count + 1;
        rd_prev <= read_strobe_pin_n_o;
        wr_prev <= write_strobe_pin_n_o;
    end
endmodule : ebi_mem_model

`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`include "ebi_defs.svh"
`default_nettype none

module tb;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, internal_rom_disable_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic cpu_req, cpu_ready, cpu_fetch, cpu_write, cpu_word, cpu_two_part, cpu_done, int_sel, er;
    logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, int_addr;
    logic [7:0] cpu_addr_code, cpu_op_code, low_addr_data_port_i, low_addr_data_port_o, high_addr_port_o;
    logic low_addr_data_port_oe, high_addr_port_oe, latch_strobe_pin_o, latch_strobe_pin_oe, fetch_strobe_n_o;
    logic write_strobe_pin_n_o, write_strobe_pin_oe, read_strobe_pin_n_o, read_strobe_pin_oe;
    logic [7:0] bop [13] = '{8'h08, 8'h0F, 8'h00, 8'h18, 8'hB8, 8'hB9, 8'hCA, 8'hBB, 8'hBA, 8'hAA, 8'hAB, 8'hC7, 8'hD7};
    logic [7:0] bad [13] = '{8'h68, 8'h6F, 8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB5, 8'hB7, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'h9B};
    logic [7:0] wad [13] = '{8'h64, 8'h67, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA5, 8'hA7, 8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'h8B};
    logic [7:0] wop [4] = '{8'hAA, 8'hAB, 8'hC7, 8'hD7};
    int bad_count = 0;
    int checks_done = 0;
    int r0, w0;

    ebi_top i_dut (.*);
    ebi_mem_model i_mem (.*);

    always #5 pclk = ~pclk;

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cpu(input logic f, w, wd, two, input logic [15:0] a, d, input logic [7:0] ac, oc);
        int n;
        n = 0;
        @(posedge pclk);
        cpu_req <= 1'b1;
        cpu_fetch <= f;
        cpu_write <= w;
        cpu_word <= wd;
        cpu_two_part <= two;
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_addr_code <= ac;
        cpu_op_code <= oc;
        @(posedge pclk);
        cpu_req <= 1'b0;
        do begin
            @(negedge pclk);
            n++;
        end while (cpu_done !== 1'b1 && n < 200);
        check(n < 200, "access never finished");
    endtask : cpu

    task automatic tp(input logic two, wd, input logic [15:0] a, d, input logic [7:0] ac, oc, input int nrd);
        r0 = i_mem.rd_count;
        w0 = i_mem.wr_count;
        cpu(1'b0, 1'b1, wd, two, a, d, ac, oc);
        check(i_mem.rd_count - r0 == nrd && i_mem.wr_count - w0 == (a > 16'h09FF ? (wd ? 2 : 1) : 0), "strobe count");
    endtask : tp

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    initial begin
        presetn = 1'b0;
        internal_rom_disable_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        {cpu_req, cpu_fetch, cpu_write, cpu_word, cpu_two_part} = '0;
        {cpu_addr, cpu_wdata, cpu_addr_code, cpu_op_code} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, `EBI_OFF_ROLE, 32'h0);
        check(rd === 32'h00000007 && latch_strobe_pin_oe === 1'b1, "strap roles");
        check(read_strobe_pin_oe === 1'b0 && write_strobe_pin_oe === 1'b0, "strobes as inputs");
        apb(1'b1, `EBI_OFF_ROLE, 32'h0000001F);
        apb(1'b0, `EBI_OFF_ROLE, 32'h0);
        check(rd === 32'h0000001F && read_strobe_pin_oe === 1'b1 && write_strobe_pin_oe === 1'b1, "roles");
        apb(1'b0, 12'h010, 32'h0);
        check(er === 1'b1 && rd === 32'h0, "unmapped offset");
        pstrb <= 4'h0;
        apb(1'b1, `EBI_OFF_DATA_WAIT, 32'h5);
        pstrb <= 4'hF;
        apb(1'b0, `EBI_OFF_DATA_WAIT, 32'h0);
        check(rd === 32'h0, "masked write ignored");
        apb(1'b1, `EBI_OFF_CODE_WAIT, 32'h2);
        tp(1'b0, 1'b0, 16'h0A00, 16'h005A, 8'h68, 8'hC7, 0);
        cpu(1'b0, 1'b0, 1'b0, 1'b0, 16'h0A00, 16'h0, 8'h0, 8'h0);
        check(cpu_rdata === 16'h005A, "byte read");
        tp(1'b1, 1'b0, 16'h09FF, 16'h0077, 8'h68, 8'hC7, 0);
        check(int_addr === 16'h09FF, "internal address");
        tp(1'b1, 1'b1, 16'hFFFE, 16'hBEEF, 8'hA0, 8'hAA, 2);
        apb(1'b0, `EBI_OFF_STATUS, 32'h0);
        check(rd === 32'h0000000A, "status after word two-part write");
        cpu(1'b0, 1'b0, 1'b1, 1'b0, 16'hFFFE, 16'h0, 8'h0, 8'h0);
        check(cpu_rdata === 16'hBEEF, "word read");
        tp(1'b0, 1'b1, 16'h0A02, 16'h1357, 8'hA0, 8'hAA, 0);
        tp(1'b1, 1'b0, 16'h1000, 16'h0011, 8'h68, 8'h90, 0);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `EBI_OFF_DATA_WAIT, 32'(3 * k));
            foreach (bop[i]) tp(1'b1, 1'b0, 16'h1000, {8'h00, bop[i]}, 8'h68, bop[i], 1);
            foreach (bad[i]) tp(1'b1, 1'b0, 16'h2001, {8'h00, bad[i]}, bad[i], 8'hC7, 1);
            foreach (wad[i]) tp(1'b1, 1'b1, 16'h3000, {wad[i], 8'h5C}, wad[i], wop[i % 4], 2);
        end
        cpu(1'b1, 1'b0, 1'b0, 1'b0, 16'h2000, 16'h0, 8'h0, 8'h0);
        @(posedge pclk);
        internal_rom_disable_n <= 1'b1;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, `EBI_OFF_ROLE, 32'h0);
        check(rd === 32'h0 && latch_strobe_pin_oe === 1'b0, "no strap with pin high");
        print_verdict();
    end

    initial begin
        repeat (30000) @(posedge pclk);
        bad_count++;
        $display("FAIL %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : tb

`default_nettype wire
